// ### timer_oc_params.svh
// register offsets, field positions, reset values and bus codes for the output-compare timer
`ifndef TIMER_OC_PARAMS_SVH
`define TIMER_OC_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFS_TIMER_CTL   8'h00
`define OFS_MODULO      8'h04
`define OFS_COUNT       8'h08
`define OFS_CHAN_BASE   8'h20
`define OFS_CHAN_END    8'h50
`define CHAN_STRIDE_LOG 3
`define OFS_CHAN_VAL_B  2

// ==========================================================
// timer control fields
`define TCTL_STOP_B     0
`define TCTL_CLR_B      1
`define TCTL_PS_LO      4
`define TCTL_PS_HI      6
`define TCTL_OVF_FLAG_B 8
`define TCTL_OVF_IE_B   9

// ==========================================================
// channel status/control fields
`define CCTL_MAX_B      0
`define CCTL_TOV_B      1
`define CCTL_ELS_LO_B   2
`define CCTL_ELS_HI_B   3
`define CCTL_MS_LO_B    4
`define CCTL_MS_HI_B    5
`define CCTL_IE_B       6
`define CCTL_FLAG_B     7

// ==========================================================
// reset values
`define RST_MODULO      16'hffff
`define RST_STOP        1'b1
`define RST_CCTL        8'h00
`define RST_CVAL        16'h0000

// ==========================================================
// bus answer codes
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// ### timer_oc_pkg.sv
// types shared by the output-compare timer
`default_nettype none
package timer_oc_pkg;

  typedef logic [15:0] count_t;
  typedef logic [7:0]  chan_ctl_t;

  // pin action on compare, edge/level select high:low
  typedef enum logic [1:0] {
    PIN_DISCONNECT = 2'b00,
    PIN_TOGGLE     = 2'b01,
    PIN_CLEAR      = 2'b10,
    PIN_SET        = 2'b11
  } pin_action_t;

endpackage
`default_nettype wire

// ### timer_output_compare_pwm.sv
// six-channel output-compare and pwm timer with an axi4-lite register port
// Functional notes
// - counter equals channel value: set, clear, toggle
// - compare sets flag; enabled flag raises irq
// - unbuffered writes replace active value at once
// - compare only when counter reaches value
// - even link bit pairs channels, even pin
// - odd write takes control at next overflow
// - each overflow selects most recently written half of pair
// - linked: even control configures, odd ignored
// - linked: odd pin released to gpio
// - toggle-on-overflow toggles pin at modulo
// - pulse width runs overflow to compare
// - period is modulo plus one prescaled ticks
// - value 128 of 256 gives 50% duty
// - compare flag at pulse end, overflow at period
// - mode bits 0:1 unbuffered, 1:0 buffered
// - edge bits 1:0 clear, 1:1 set
// - no toggle-on-overflow gives 0% duty
// - max bit with toggle gives 100% duty
`timescale 1ns/1ps
`default_nettype none
`include "timer_oc_params.svh"

module timer_output_compare_pwm
  import timer_oc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   chan0_output_pin,
  output logic                   chan0_output_oe,
  output logic                   chan1_output_pin,
  output logic                   chan1_output_oe,
  output logic                   chan2_output_pin,
  output logic                   chan2_output_oe,
  output logic                   chan3_output_pin,
  output logic                   chan3_output_oe,
  output logic                   chan4_output_pin,
  output logic                   chan4_output_oe,
  output logic                   chan5_output_pin,
  output logic                   chan5_output_oe,
  output logic [5:0]             chan_irq,
  output logic                   overflow_irq
);

  localparam int NCH   = 6;
  localparam int NPAIR = 3;

  // ==========================================================
  // helper functions
  function automatic logic is_chan(input logic [ADDR_W-1:0] a);
    is_chan = (a[7:0] >= `OFS_CHAN_BASE) && (a[7:0] < `OFS_CHAN_END);
  endfunction

  function automatic logic [2:0] chan_idx(input logic [ADDR_W-1:0] a);
    logic [7:0] rel;
    rel = a[7:0] - `OFS_CHAN_BASE;
    chan_idx = rel[`CHAN_STRIDE_LOG+2:`CHAN_STRIDE_LOG];
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'b00) && (is_chan(a) || a[7:0] == `OFS_TIMER_CTL
              || a[7:0] == `OFS_MODULO || a[7:0] == `OFS_COUNT);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  function automatic logic presc_done(input logic [6:0] cnt, input logic [2:0] ps);
    logic [6:0] mask;
    mask = 7'h7f >> (3'h7 - ((ps == 3'h7) ? 3'h6 : ps));
    presc_done = &(cnt | ~mask);
  endfunction

  // ==========================================================
  // state
  count_t    cnt_ff;
  count_t    mod_ff;
  logic      stop_ff;
  logic      ovf_flag_ff;
  logic      ovf_ie_ff;
  logic [2:0] ps_ff;
  logic [6:0] presc_ff;
  chan_ctl_t ctl_ff [NCH];
  count_t    val_ff [NCH];
  logic [NCH-1:0] pin_ff;
  logic [NPAIR-1:0] act_ff;
  logic [NPAIR-1:0] last_ff;

  logic [ADDR_W-1:0] awaddr_ff;
  logic        aw_got_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        w_got_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;

  // ==========================================================
  // bus decode
  wire wr_do      = aw_got_ff && w_got_ff && !bvalid_ff;
  wire wr_ok      = wr_do && addr_ok(awaddr_ff);
  wire wr_chan    = wr_ok && is_chan(awaddr_ff);
  wire [2:0] wr_c = chan_idx(awaddr_ff);
  wire wr_is_val  = awaddr_ff[`OFS_CHAN_VAL_B];
  wire wr_tctl    = wr_ok && awaddr_ff[7:0] == `OFS_TIMER_CTL;
  wire wr_mod     = wr_ok && awaddr_ff[7:0] == `OFS_MODULO;
  wire rd_take    = s_axi_arvalid && !rvalid_ff;
  wire [2:0] rd_c = chan_idx(s_axi_araddr);

  wire [31:0] tctl_rd = {22'h0, ovf_ie_ff, ovf_flag_ff, 1'b0, ps_ff, 2'b00, 1'b0, stop_ff};
  wire [31:0] tctl_wr = merge(tctl_rd, wdata_ff, wstrb_ff);
  wire [31:0] mod_wr  = merge({16'h0, mod_ff}, wdata_ff, wstrb_ff);
  wire [31:0] ctl_wr  = merge({24'h0, ctl_ff[wr_c]}, wdata_ff, wstrb_ff);
  wire [31:0] val_wr  = merge({16'h0, val_ff[wr_c]}, wdata_ff, wstrb_ff);
  wire        clr_cnt = wr_tctl && tctl_wr[`TCTL_CLR_B];

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // ==========================================================
  // counter timing
  wire tick = !stop_ff && presc_done(presc_ff, ps_ff);
  wire ovf  = tick && (cnt_ff == mod_ff);
  // count being reached at this tick
  wire [15:0] cnt_step = ovf ? 16'h0000 : cnt_ff + 16'h0001;

  // ==========================================================
  // per-channel compare and pin logic
  logic [NCH-1:0] link_of;
  logic [NCH-1:0] oc_en;
  logic [NCH-1:0] match;
  logic [NCH-1:0] nxt_pin;
  count_t         cmp_val [NCH];
  chan_ctl_t      nxt_ctl [NCH];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      link_of[c] = ctl_ff[c & ~1][`CCTL_MS_HI_B];
      // linked even channel follows the active half of the pair
      cmp_val[c] = (c % 2 == 0 && link_of[c] && act_ff[c/2]) ? val_ff[c | 1] : val_ff[c];
      // odd half of a linked pair is inert
      oc_en[c]   = (ctl_ff[c][`CCTL_MS_HI_B] || ctl_ff[c][`CCTL_MS_LO_B])
                   && !(c % 2 == 1 && link_of[c]);
      match[c]   = oc_en[c] && tick && (cnt_step == cmp_val[c]);
      nxt_pin[c] = pin_ff[c];
      if (oc_en[c]) begin
        if (ovf && ctl_ff[c][`CCTL_TOV_B]) begin
          nxt_pin[c] = ~pin_ff[c];
        end
        if (match[c]) begin
          case (pin_action_t'(ctl_ff[c][`CCTL_ELS_HI_B:`CCTL_ELS_LO_B]))
            PIN_TOGGLE: nxt_pin[c] = ~pin_ff[c];
            PIN_CLEAR:  nxt_pin[c] = 1'b0;
            PIN_SET:    nxt_pin[c] = 1'b1;
            default:    nxt_pin[c] = nxt_pin[c];
          endcase
        end
        if (ctl_ff[c][`CCTL_MAX_B] && ctl_ff[c][`CCTL_TOV_B]) begin
          nxt_pin[c] = ~ctl_ff[c][`CCTL_ELS_LO_B];
        end
      end
      nxt_ctl[c] = ctl_ff[c];
      if (wr_chan && !wr_is_val && wr_c == 3'(c)) begin
        nxt_ctl[c] = ctl_wr[7:0];
        nxt_ctl[c][`CCTL_FLAG_B] = ctl_ff[c][`CCTL_FLAG_B]
                                   && !(wstrb_ff[0] && wdata_ff[`CCTL_FLAG_B]);
      end
      if (match[c]) begin
        nxt_ctl[c][`CCTL_FLAG_B] = 1'b1;
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      chan_irq[c] = ctl_ff[c][`CCTL_FLAG_B] && ctl_ff[c][`CCTL_IE_B];
    end
  end

  assign overflow_irq     = ovf_flag_ff && ovf_ie_ff;
  assign chan0_output_pin = pin_ff[0];
  assign chan1_output_pin = pin_ff[1];
  assign chan2_output_pin = pin_ff[2];
  assign chan3_output_pin = pin_ff[3];
  assign chan4_output_pin = pin_ff[4];
  assign chan5_output_pin = pin_ff[5];

  // pin released when no compare mode or no pin action; odd pin freed while linked
  wire [NCH-1:0] drive_en;
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_oe
      assign drive_en[g] = oc_en[g] && (ctl_ff[g][`CCTL_ELS_HI_B:`CCTL_ELS_LO_B] != 2'b00);
    end
  endgenerate
  assign chan0_output_oe = drive_en[0];
  assign chan1_output_oe = drive_en[1];
  assign chan2_output_oe = drive_en[2];
  assign chan3_output_oe = drive_en[3];
  assign chan4_output_oe = drive_en[4];
  assign chan5_output_oe = drive_en[5];

  // ==========================================================
  // timer core registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff   <= 16'h0000;
      presc_ff <= 7'h00;
    end else if (clr_cnt) begin
      cnt_ff   <= 16'h0000;
      presc_ff <= 7'h00;
    end else if (!stop_ff) begin
      presc_ff <= tick ? 7'h00 : presc_ff + 7'h01;
      if (tick) begin
        cnt_ff <= cnt_step;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mod_ff      <= `RST_MODULO;
      stop_ff     <= `RST_STOP;
      ps_ff       <= 3'h0;
      ovf_ie_ff   <= 1'b0;
      ovf_flag_ff <= 1'b0;
    end else begin
      if (wr_mod) begin
        mod_ff <= mod_wr[15:0];
      end
      if (wr_tctl) begin
        stop_ff   <= tctl_wr[`TCTL_STOP_B];
        ps_ff     <= tctl_wr[`TCTL_PS_HI:`TCTL_PS_LO];
        ovf_ie_ff <= tctl_wr[`TCTL_OVF_IE_B];
      end
      // set wins over a clear in the same cycle
      ovf_flag_ff <= ovf || (ovf_flag_ff
                     && !(wr_tctl && wstrb_ff[1] && wdata_ff[`TCTL_OVF_FLAG_B]));
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int c = 0; c < NCH; c++) begin
        ctl_ff[c] <= `RST_CCTL;
        val_ff[c] <= `RST_CVAL;
      end
      pin_ff <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        ctl_ff[c] <= nxt_ctl[c];
        if (wr_chan && wr_is_val && wr_c == 3'(c)) begin
          val_ff[c] <= val_wr[15:0];
        end
      end
      pin_ff <= nxt_pin;
    end
  end

  // ==========================================================
  // buffered pair hand-over
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_ff  <= '0;
      last_ff <= '0;
    end else begin
      for (int p = 0; p < NPAIR; p++) begin
        if (!link_of[2*p]) begin
          act_ff[p]  <= 1'b0;
          last_ff[p] <= 1'b0;
        end else begin
          if (wr_chan && wr_is_val && wr_c[2:1] == 2'(p)) begin
            last_ff[p] <= wr_c[0];
          end
          if (ovf) begin
            act_ff[p] <= last_ff[p];
          end
        end
      end
    end
  end

  // ==========================================================
  // axi4-lite write channel
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awaddr_ff <= '0;
      aw_got_ff <= 1'b0;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
      w_got_ff  <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff <= s_axi_awaddr;
        aw_got_ff <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        w_got_ff <= 1'b1;
      end
      if (wr_do) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  wire [31:0] rd_mux =
    (s_axi_araddr[7:0] == `OFS_TIMER_CTL) ? tctl_rd :
    (s_axi_araddr[7:0] == `OFS_MODULO)    ? {16'h0, mod_ff} :
    (s_axi_araddr[7:0] == `OFS_COUNT)     ? {16'h0, cnt_ff} :
    s_axi_araddr[`OFS_CHAN_VAL_B]         ? {16'h0, val_ff[rd_c]} :
                                            {24'h0, ctl_ff[rd_c]};

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= `RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= addr_ok(s_axi_araddr) ? rd_mux : 32'h0;
      rresp_ff  <= addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### pwm_pin_load.sv
// external load on a timer pin: pull-down line plus high-time meter
`timescale 1ns/1ps
`default_nettype none

module pwm_pin_load (
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        pin,
  input  wire logic        oe,
  output logic             line,
  output logic [15:0]      high_cnt_ff
);
  // ==========================================================
  // wire level: released pin falls to the pull-down
  assign line = oe ? pin : 1'b0;

  // ==========================================================
  // cycles seen high since the last clear
  always_ff @(posedge clk) begin
    if (clr) begin
      high_cnt_ff <= 16'h0000;
    end else if (line) begin
      high_cnt_ff <= high_cnt_ff + 16'h0001;
    end
  end
endmodule

`default_nettype wire

// ### timer_output_compare_pwm_properties.sv
// assertions on the register port and outputs of the output-compare timer
`timescale 1ns/1ps
`default_nettype none

module timer_output_compare_pwm_properties (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        chan0_output_pin,
  input wire logic [5:0]  chan_irq,
  input wire logic        overflow_irq
);
  logic wr_seen_ff;

  // ==========================================================
  // no write taken yet: timer still stopped
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_seen_ff <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      wr_seen_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // bus answers
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed before bready");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stayed after bready");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped or changed before rready");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");

  // ==========================================================
  // outputs
  a_chan_irq_clear: assert property ((($past(chan_irq) & ~chan_irq) != 6'h00) |-> $rose(s_axi_bvalid))
    else $error("channel request fell without a write");
  a_ovf_irq_clear: assert property ($fell(overflow_irq) |-> $rose(s_axi_bvalid))
    else $error("overflow request fell without a write");
  a_idle_reset: assert property (!wr_seen_ff |-> !chan0_output_pin && chan_irq == 6'h00 && !overflow_irq)
    else $error("timer active before any write");
endmodule

bind timer_output_compare_pwm timer_output_compare_pwm_properties i_props (
  .ref_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan0_output_pin, .chan_irq, .overflow_irq);

`default_nettype wire

// ### timer_output_compare_pwm_bench.sv
// self-checking bench for the output-compare timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_oc_params.svh"

module timer_output_compare_pwm_bench;
  logic        ref_clk, sys_rst, load_clr, line0, line1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        chan0_output_pin, chan1_output_pin, chan2_output_pin, chan3_output_pin;
  logic        chan4_output_pin, chan5_output_pin, chan0_output_oe, chan1_output_oe;
  logic        chan2_output_oe, chan3_output_oe, chan4_output_oe, chan5_output_oe;
  logic [5:0]  chan_irq;
  logic        overflow_irq;
  logic [15:0] high0, high1;
  int          errors, checked, cycles;

  timer_output_compare_pwm i_timer_output_compare_pwm (
    .ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .chan0_output_pin, .chan0_output_oe, .chan1_output_pin,
    .chan1_output_oe, .chan2_output_pin, .chan2_output_oe, .chan3_output_pin,
    .chan3_output_oe, .chan4_output_pin, .chan4_output_oe, .chan5_output_pin,
    .chan5_output_oe, .chan_irq, .overflow_irq);
  pwm_pin_load i_pwm_pin_load (.clk(ref_clk), .clr(load_clr), .pin(chan0_output_pin),
    .oe(chan0_output_oe), .line(line0), .high_cnt_ff(high0));
  pwm_pin_load i_pwm_pin_load_odd (.clk(ref_clk), .clr(load_clr), .pin(chan1_output_pin),
    .oe(chan1_output_oe), .line(line1), .high_cnt_ff(high1));

  // ==========================================================
  // clock, timeout, shared tasks
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (!ad && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (!wd && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        wd = 1'b1;
      end
    end while (!(ad && wd));
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    chk("rdata", s_axi_rdata, exp);
  endtask

  // settle two periods, then count high cycles over four periods of 256
  task automatic measure(input string nm, input logic [15:0] exp);
    repeat (600) @(posedge ref_clk);
    load_clr <= 1'b1;
    @(posedge ref_clk);
    load_clr <= 1'b0;
    repeat (1025) @(posedge ref_clk);
    chk(nm, {16'h0, high0}, {16'h0, exp});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_regs();
    rd(`OFS_MODULO, 32'h0000ffff, `RESP_OKAY);
    rd(`OFS_TIMER_CTL, 32'h00000001, `RESP_OKAY);
    rd(8'h20, 32'h00000000, `RESP_OKAY);
    rd(8'h60, 32'h00000000, `RESP_SLVERR);
    wr(8'h60, 32'h00000000, `RESP_SLVERR);
  endtask

  task automatic t_pwm_duty();
    logic [15:0] v [4];
    v = '{16'h0001, 16'h0040, 16'h0080, 16'h00c8};
    wr(`OFS_MODULO, 32'h000000ff, `RESP_OKAY);
    wr(8'h20, 32'h0000005a, `RESP_OKAY);
    wr(`OFS_TIMER_CTL, 32'h00000200, `RESP_OKAY);
    foreach (v[i]) begin
      // longer pulse: write from the overflow event
      wr(`OFS_TIMER_CTL, 32'h00000300, `RESP_OKAY);
      do @(posedge ref_clk); while (overflow_irq !== 1'b1);
      wr(8'h24, {16'h0, v[i]}, `RESP_OKAY);
      measure("duty", {v[i][13:0], 2'b00});
    end
    chk("chan_irq", 32'(chan_irq[0]), 32'h1);
    chk("overflow_irq", 32'(overflow_irq), 32'h1);
    wr(`OFS_TIMER_CTL, 32'h00000201, `RESP_OKAY);
    rd(8'h20, 32'h000000da, `RESP_OKAY);
    wr(8'h20, 32'h000000da, `RESP_OKAY);
    chk("chan_irq clear", 32'(chan_irq[0]), 32'h0);
    wr(`OFS_TIMER_CTL, 32'h00000301, `RESP_OKAY);
    chk("overflow_irq clear", 32'(overflow_irq), 32'h0);
    wr(`OFS_TIMER_CTL, 32'h00000000, `RESP_OKAY);
  endtask

  task automatic t_edge_modes();
    // shorter pulse: write from the compare event
    wr(8'h20, 32'h000000da, `RESP_OKAY);
    do @(posedge ref_clk); while (chan_irq[0] !== 1'b1);
    wr(8'h24, 32'h00000040, `RESP_OKAY);
    wr(8'h20, 32'h00000018, `RESP_OKAY);
    measure("zero duty", 16'h0000);
    wr(8'h20, 32'h0000001b, `RESP_OKAY);
    measure("full duty", 16'h0400);
    wr(8'h20, 32'h0000001e, `RESP_OKAY);
    measure("set on compare", 16'h0300);
  endtask

  task automatic t_buffered();
    wr(8'h20, 32'h0000001a, `RESP_OKAY);
    wr(8'h28, 32'h0000001a, `RESP_OKAY);
    chk("odd oe unlinked", 32'(chan1_output_oe), 32'h1);
    wr(8'h20, 32'h0000002a, `RESP_OKAY);
    chk("odd oe linked", 32'(chan1_output_oe), 32'h0);
    chk("odd line", 32'(line1), 32'h0);
    measure("even first", 16'h0100);
    wr(8'h2c, 32'h00000020, `RESP_OKAY);
    wr(8'h28, 32'h0000001e, `RESP_OKAY);
    measure("odd takes over", 16'h0080);
    wr(8'h24, 32'h00000064, `RESP_OKAY);
    measure("last written", 16'h0190);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    errors = 0;
    checked = 0;
    cycles = 0;
    sys_rst = 1'b1;
    load_clr = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset_regs();
    t_pwm_duty();
    t_edge_modes();
    t_buffered();
    print_verdict();
  end
endmodule

`default_nettype wire
